// ---- logic/qdw_wiper_ctrl.sv ----
// Behaviour
// - Four channels, each with one volatile wiper position register driving its tap.
// - Wiper position is eight bits, selecting one of 256 taps.
// - Each channel owns four stored-value registers, writable and readable serially.
// - After reset the first stored value of each channel loads its wiper.
// - Serial slave samples incoming data bits on rising serial clock edges.
// - Returned data bits change after each falling serial clock edge.
// - Data line is only pulled low; an external pull-up gives highs.
// - One serial clock input clocks both serial and stepping interfaces.
// - Three strap inputs form the low three bits of the address byte.
// - Transactions start only when the address matches the straps; else ignored.
// - Chip select low enables stepping and disables the serial interface.
// - Chip select high enables the serial interface and stops stepping.
// - Two select inputs choose the channel for stepping or store.
// - Write protect low refuses every stored-value write.
// - Protection covers serial stored-value writes and the stepping store.
// - Serial write, read and transfer operations on all registers.
`timescale 1ns/1ps
`default_nettype none
module qdw_wiper_ctrl
    import qdw_pkg::*;
#(
    parameter logic [7:0] NV_RESET = QDW_NV_RESET
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic chip_sel,
    input wire logic step_up,
    input wire logic channel_sel_lo,
    input wire logic channel_sel_hi,
    input wire logic addr_strap_0,
    input wire logic addr_strap_1,
    input wire logic addr_strap_2,
    input wire logic write_protect_n,
    input wire logic store_req,
    output logic [QDW_POS_W-1:0] wiper_position_0,
    output logic [QDW_POS_W-1:0] wiper_position_1,
    output logic [QDW_POS_W-1:0] wiper_position_2,
    output logic [QDW_POS_W-1:0] wiper_position_3
);
    function automatic logic [QDW_IDX_W-1:0] nv_idx(input logic [QDW_CH_W-1:0] ch,
                                                    input logic [QDW_NV_W-1:0] rg);
        nv_idx = {ch, rg};
    endfunction : nv_idx

    function automatic logic [QDW_POS_W-1:0] step_pos(input logic [QDW_POS_W-1:0] pos,
                                                      input logic up);
        if (up)
        begin
            step_pos = (pos == QDW_POS_MAX) ? pos : pos + 8'h01;
        end
        else
        begin
            step_pos = (pos == QDW_POS_MIN) ? pos : pos - 8'h01;
        end
    endfunction : step_pos

    logic rst_s1;
    logic rst_s2;
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end
        else if (clk_en)
        begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end
    logic rst_n;
    assign rst_n = rst_s2;

    // The serial, stepping, strap, protect and store pins are asynchronous to clock, so all pass two flip-flops first.
    logic [QDW_SYNC_W-1:0] pin_raw;
    logic [QDW_SYNC_W-1:0] sync1;
    logic [QDW_SYNC_W-1:0] sync2;
    logic scl_prev;
    logic sda_prev;
    logic store_prev;
    assign pin_raw = {store_req, write_protect_n, addr_strap_2, addr_strap_1, addr_strap_0,
                      channel_sel_hi, channel_sel_lo, step_up, chip_sel, sda_in, scl,
                      2'b00};
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1 <= '0;
            sync2 <= '0;
            scl_prev <= 1'b0;
            sda_prev <= 1'b1;
            store_prev <= 1'b0;
        end
        else if (clk_en)
        begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            scl_prev <= sync2[2];
            sda_prev <= sync2[3];
            store_prev <= sync2[12];
        end
    end
    logic scl_s;
    logic sda_s;
    logic cs_s;
    logic up_s;
    logic [QDW_CH_W-1:0] chsel_s;
    logic [2:0] strap_s;
    logic wp_allow;
    logic store_s;
    assign scl_s = sync2[2];
    assign sda_s = sync2[3];
    assign cs_s = sync2[4];
    assign up_s = sync2[5];
    assign chsel_s = sync2[7:6];
    assign strap_s = sync2[10:8];
    assign wp_allow = sync2[11];
    assign store_s = sync2[12];

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    assign scl_rise = scl_s & ~scl_prev;
    assign scl_fall = ~scl_s & scl_prev;
    assign bus_start = scl_s & scl_prev & sda_prev & ~sda_s;
    assign bus_stop = scl_s & scl_prev & ~sda_prev & sda_s;

    logic [QDW_POS_W-1:0] wiper [QDW_NUM_CH];
    logic [QDW_POS_W-1:0] nv_mem [QDW_NUM_CH*QDW_NUM_NV];

    qdw_state_e st;
    qdw_state_e next_st;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [7:0] sh;
    logic [7:0] next_sh;
    logic ack_pend;
    logic next_ack_pend;
    logic in_ack;
    logic next_in_ack;
    logic drv;
    logic next_drv;
    logic wr_wiper;
    logic wr_nv;
    logic [QDW_IDX_W-1:0] wr_idx;
    logic [QDW_POS_W-1:0] wr_data;
    logic [7:0] instr;
    logic [7:0] next_instr;
    logic [7:0] rx_byte;
    logic [QDW_IDX_W-1:0] rx_idx;
    logic [QDW_IDX_W-1:0] ins_idx;
    logic [QDW_CH_W-1:0] rx_ch;
    assign rx_byte = {sh[6:0], sda_s};
    assign rx_ch = rx_byte[QDW_CSEL_HI:QDW_CSEL_LO];
    assign rx_idx = nv_idx(rx_ch, rx_byte[QDW_RSEL_HI:QDW_RSEL_LO]);
    assign ins_idx = nv_idx(instr[QDW_CSEL_HI:QDW_CSEL_LO], instr[QDW_RSEL_HI:QDW_RSEL_LO]);

    always_comb
    begin
        next_st = st;
        next_cnt = cnt;
        next_sh = sh;
        next_ack_pend = ack_pend;
        next_in_ack = in_ack;
        next_drv = drv;
        next_instr = instr;
        wr_wiper = 1'b0;
        wr_nv = 1'b0;
        wr_idx = rx_idx;
        wr_data = rx_byte;
        if (!cs_s || bus_stop)
        begin
            next_st = QDW_IDLE;
            next_ack_pend = 1'b0;
            next_in_ack = 1'b0;
            next_drv = 1'b0;
        end
        else if (bus_start)
        begin
            next_st = QDW_ADDR;
            next_cnt = QDW_CNT_ZERO;
            next_ack_pend = 1'b0;
            next_in_ack = 1'b0;
            next_drv = 1'b0;
        end
        else if (scl_fall)
        begin
            if (ack_pend)
            begin
                next_drv = 1'b1;
                next_in_ack = 1'b1;
                next_ack_pend = 1'b0;
            end
            else
            begin
                next_in_ack = 1'b0;
                next_drv = (st == QDW_RDATA) && (cnt < QDW_RD_END) && !sh[7];
            end
        end
        else if (scl_rise && !in_ack)
        begin
            unique case (st)
                QDW_IDLE, QDW_DONE:
                begin
                    next_st = st;
                end
                QDW_RDATA:
                begin
                    next_sh = {sh[6:0], 1'b0};
                    next_cnt = cnt + QDW_CNT_ONE;
                    if (cnt == QDW_RD_END)
                    begin
                        next_st = QDW_DONE;
                    end
                end
                QDW_ADDR, QDW_INSTR, QDW_WDATA:
                begin
                    next_sh = rx_byte;
                    next_cnt = cnt + QDW_CNT_ONE;
                    if (cnt == QDW_BIT_LAST)
                    begin
                        next_cnt = QDW_CNT_ZERO;
                        next_st = QDW_DONE;
                        if (st == QDW_ADDR)
                        begin
                            if (rx_byte == {QDW_DEV_TYPE, strap_s})
                            begin
                                next_ack_pend = 1'b1;
                                next_st = QDW_INSTR;
                            end
                            else
                            begin
                                next_st = QDW_IDLE;
                            end
                        end
                        else if (st == QDW_INSTR)
                        begin
                            next_instr = rx_byte;
                            next_ack_pend = 1'b1;
                            unique case (rx_byte[QDW_OP_HI:QDW_OP_LO])
                                QDW_OP_WR_WIPER, QDW_OP_WR_NV:
                                begin
                                    next_st = QDW_WDATA;
                                end
                                QDW_OP_RD_WIPER:
                                begin
                                    next_sh = wiper[rx_ch];
                                    next_st = QDW_RDATA;
                                end
                                QDW_OP_RD_NV:
                                begin
                                    next_sh = nv_mem[rx_idx];
                                    next_st = QDW_RDATA;
                                end
                                QDW_OP_NV_TO_WIPER:
                                begin
                                    wr_wiper = 1'b1;
                                    wr_data = nv_mem[rx_idx];
                                end
                                QDW_OP_WIPER_TO_NV:
                                begin
                                    wr_nv = wp_allow;
                                    wr_data = wiper[rx_ch];
                                end
                                default:
                                begin
                                    next_ack_pend = 1'b0;
                                end
                            endcase
                        end
                        else
                        begin
                            next_ack_pend = 1'b1;
                            wr_idx = ins_idx;
                            if (instr[QDW_OP_HI:QDW_OP_LO] == QDW_OP_WR_NV)
                            begin
                                wr_nv = wp_allow;
                            end
                            else
                            begin
                                wr_wiper = 1'b1;
                            end
                        end
                    end
                end
                default:
                begin
                    next_st = QDW_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= QDW_IDLE;
            cnt <= QDW_CNT_ZERO;
            sh <= '0;
            ack_pend <= 1'b0;
            in_ack <= 1'b0;
            drv <= 1'b0;
            instr <= '0;
        end
        else if (clk_en)
        begin
            st <= next_st;
            cnt <= next_cnt;
            sh <= next_sh;
            ack_pend <= next_ack_pend;
            in_ack <= next_in_ack;
            drv <= next_drv;
            instr <= next_instr;
        end
    end

    // The pin only ever pulls low; a released line floats high on the pull-up.
    assign sda_out = 1'b0;
    assign sda_oe = drv;

    // Recall runs in the first enabled cycle after reset release, so the
    // stored values are already settled when they are copied.
    logic recall;
    logic next_recall;
    logic [QDW_POS_W-1:0] next_wiper [QDW_NUM_CH];
    logic [QDW_POS_W-1:0] next_nv [QDW_NUM_CH*QDW_NUM_NV];
    logic store_edge;
    assign store_edge = store_s & ~store_prev & ~cs_s;

    always_comb
    begin
        next_recall = 1'b0;
        next_wiper = wiper;
        next_nv = nv_mem;
        if (recall)
        begin
            for (int i = 0; i < QDW_NUM_CH; i++)
            begin
                next_wiper[i] = nv_mem[nv_idx(QDW_CH_W'(i), QDW_DEFAULT_NV)];
            end
        end
        else if (!cs_s)
        begin
            if (scl_rise)
            begin
                next_wiper[chsel_s] = step_pos(wiper[chsel_s], up_s);
            end
            if (store_edge && wp_allow)
            begin
                next_nv[nv_idx(chsel_s, QDW_DEFAULT_NV)] = wiper[chsel_s];
            end
        end
        else
        begin
            if (wr_wiper)
            begin
                next_wiper[wr_idx[QDW_IDX_W-1:QDW_NV_W]] = wr_data;
            end
            if (wr_nv)
            begin
                next_nv[wr_idx] = wr_data;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            recall <= 1'b1;
            wiper <= '{default: QDW_POS_MIN};
            nv_mem <= '{default: NV_RESET};
        end
        else if (clk_en)
        begin
            recall <= next_recall;
            wiper <= next_wiper;
            nv_mem <= next_nv;
        end
    end

    assign wiper_position_0 = wiper[0];
    assign wiper_position_1 = wiper[1];
    assign wiper_position_2 = wiper[2];
    assign wiper_position_3 = wiper[3];
endmodule : qdw_wiper_ctrl
`default_nettype wire

// ---- logic/qdw_pkg.sv ----
`default_nettype none
package qdw_pkg;
    localparam int QDW_POS_W = 8;
    localparam int QDW_NUM_CH = 4;
    localparam int QDW_NUM_NV = 4;
    localparam int QDW_CH_W = 2;
    localparam int QDW_NV_W = 2;
    localparam int QDW_IDX_W = 4;
    localparam logic [7:0] QDW_POS_MIN = 8'h00;
    localparam logic [7:0] QDW_POS_MAX = 8'hff;
    localparam logic [7:0] QDW_NV_RESET = 8'h80;
    // Upper five bits of the slave address byte; the value is arbitrary.
    localparam logic [4:0] QDW_DEV_TYPE = 5'h0a;
    localparam logic [1:0] QDW_DEFAULT_NV = 2'h0;
    localparam logic [3:0] QDW_BIT_LAST = 4'h7;
    localparam logic [3:0] QDW_RD_END = 4'h8;
    localparam logic [3:0] QDW_CNT_ZERO = 4'h0;
    localparam logic [3:0] QDW_CNT_ONE = 4'h1;
    localparam int QDW_OP_HI = 7;
    localparam int QDW_OP_LO = 4;
    localparam int QDW_CSEL_HI = 3;
    localparam int QDW_CSEL_LO = 2;
    localparam int QDW_RSEL_HI = 1;
    localparam int QDW_RSEL_LO = 0;
    localparam logic [3:0] QDW_OP_RD_WIPER = 4'h9;
    localparam logic [3:0] QDW_OP_WR_WIPER = 4'ha;
    localparam logic [3:0] QDW_OP_RD_NV = 4'hb;
    localparam logic [3:0] QDW_OP_WR_NV = 4'hc;
    localparam logic [3:0] QDW_OP_NV_TO_WIPER = 4'hd;
    localparam logic [3:0] QDW_OP_WIPER_TO_NV = 4'he;
    localparam int QDW_SYNC_W = 13;
    typedef enum logic [2:0] {
        QDW_IDLE = 3'h0,
        QDW_ADDR = 3'h1,
        QDW_INSTR = 3'h2,
        QDW_WDATA = 3'h3,
        QDW_RDATA = 3'h4,
        QDW_DONE = 3'h5
    } qdw_state_e;
endpackage : qdw_pkg
`default_nettype wire

// ---- verification/qdw_wiper_ctrl_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module qdw_chk
    import qdw_pkg::*;
#(
    parameter logic [7:0] NV_RESET = QDW_NV_RESET
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic scl,
    input wire logic chip_sel,
    input wire logic step_up,
    input wire logic channel_sel_lo,
    input wire logic channel_sel_hi,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic [QDW_POS_W-1:0] wiper_position_0,
    input wire logic [QDW_POS_W-1:0] wiper_position_1
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!nrst);
    a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl)
        else $error("data line moved while serial clock high");
    a_open_drain: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    a_step_up: assert property (!chip_sel && $rose(scl) && step_up && !channel_sel_hi
        && !channel_sel_lo |-> ##[3:4] wiper_position_0 == (($past(wiper_position_0, 3)
        == 8'hff) ? 8'hff : $past(wiper_position_0, 3) + 8'h01))
        else $error("increment step wrong");
    a_step_down: assert property (!chip_sel && $rose(scl) && !step_up && !channel_sel_hi
        && channel_sel_lo |-> ##[3:4] wiper_position_1 == (($past(wiper_position_1, 3)
        == 8'h00) ? 8'h00 : $past(wiper_position_1, 3) - 8'h01))
        else $error("decrement step wrong");
    a_other_hold: assert property (!chip_sel && $rose(scl) && !channel_sel_hi
        && !channel_sel_lo |-> $stable(wiper_position_1) [*6])
        else $error("unselected wiper moved");
    a_serial_off: assert property (!chip_sel [*6] |-> !sda_oe)
        else $error("data line pulled in stepping mode");
    a_recall: assert property ($rose(nrst) |-> ##[1:4] (wiper_position_0 == NV_RESET
        && wiper_position_1 == NV_RESET))
        else $error("power-up recall missing");
    a_idle_hold: assert property ((!chip_sel && !scl) [*6] |-> $stable(wiper_position_0))
        else $error("wiper moved without a step");
endmodule : qdw_chk
bind qdw_wiper_ctrl qdw_chk #(.NV_RESET(NV_RESET)) qdw_chk_inst (
    .clock(clock), .nrst(nrst), .scl(scl), .chip_sel(chip_sel), .step_up(step_up),
    .channel_sel_lo(channel_sel_lo), .channel_sel_hi(channel_sel_hi), .sda_out(sda_out),
    .sda_oe(sda_oe), .wiper_position_0(wiper_position_0), .wiper_position_1(wiper_position_1)
);
`default_nettype wire

// ---- verification/qdw_mstr.sv ----
`timescale 1ns/1ps
`default_nettype none
module qdw_mstr (
    input wire logic clock,
    input wire logic sda_oe,
    output logic scl,
    output logic sda_line,
    output logic step_up,
    output logic channel_sel_lo,
    output logic channel_sel_hi
);
    logic m_low;
    // Either party pulling low wins; otherwise the pull-up gives a high.
    assign sda_line = ~(m_low | sda_oe);
    initial
    begin
        m_low = 1'b0;
        scl = 1'b0;
        step_up = 1'b0;
        {channel_sel_hi, channel_sel_lo} = 2'h0;
    end
    task automatic half();
        repeat (4) @(negedge clock);
    endtask : half
    // Data moves only while the clock is low, so it never looks like a start or stop.
    task automatic bit_io(input logic b, output logic r);
        m_low = ~b;
        half();
        scl = 1'b1;
        half();
        r = sda_line;
        scl = 1'b0;
    endtask : bit_io
    task automatic cond(input logic is_stop);
        m_low = is_stop;
        half();
        scl = 1'b1;
        half();
        m_low = ~is_stop;
        half();
        scl = 1'b0;
    endtask : cond
    // A read passes all ones so the line is free for the device; the ninth bit is always released.
    task automatic send(input logic [7:0] b, output logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], d[i]);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : send
    task automatic step(input logic up, input logic [1:0] ch);
        step_up = up;
        {channel_sel_hi, channel_sel_lo} = ch;
        half();
        scl = 1'b1;
        half();
        scl = 1'b0;
    endtask : step
endmodule : qdw_mstr
`default_nettype wire

// ---- verification/qdw_wiper_ctrl_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module qdw_wiper_ctrl_test;
    import qdw_pkg::*;
    localparam logic [7:0] NVR = 8'hfe;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic chip_sel = 1'b1;
    logic wp_n = 1'b0;
    logic store_req = 1'b0;
    logic clk_en = 1'b1;
    logic [2:0] strap = 3'h5;
    logic scl, sda_line, sda_out, sda_oe, step_up, sel_lo, sel_hi;
    logic [7:0] w0, w1, w2, w3, q;
    int error_cnt = 0;
    int n_checks = 0;
    always #2 clock = ~clock;
    qdw_wiper_ctrl #(.NV_RESET(NVR)) qdw_wiper_ctrl_inst (
        .clock(clock), .nrst(nrst), .clk_en(clk_en), .scl(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .chip_sel(chip_sel), .step_up(step_up),
        .channel_sel_lo(sel_lo), .channel_sel_hi(sel_hi), .addr_strap_0(strap[0]),
        .addr_strap_1(strap[1]), .addr_strap_2(strap[2]), .write_protect_n(wp_n),
        .store_req(store_req), .wiper_position_0(w0), .wiper_position_1(w1),
        .wiper_position_2(w2), .wiper_position_3(w3)
    );
    qdw_mstr qdw_mstr_inst (
        .clock(clock), .sda_oe(sda_oe), .scl(scl), .sda_line(sda_line), .step_up(step_up),
        .channel_sel_lo(sel_lo), .channel_sel_hi(sel_hi)
    );
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask : idle
    task automatic store();
        store_req = 1'b1;
        idle(8);
        store_req = 1'b0;
        idle(8);
    endtask : store
    // One serial operation per start; a read leaves its byte in q.
    task automatic op(input logic [2:0] adr, input logic [7:0] ins, input logic [7:0] d,
        input logic [1:0] ack_exp);
        logic [1:0] ack;
        logic [7:0] junk;
        logic rd;
        rd = (ins[7:4] == QDW_OP_RD_WIPER) || (ins[7:4] == QDW_OP_RD_NV);
        qdw_mstr_inst.cond(1'b0);
        qdw_mstr_inst.send({QDW_DEV_TYPE, adr}, junk, ack[1]);
        qdw_mstr_inst.send(ins, junk, ack[0]);
        qdw_mstr_inst.send(rd ? 8'hff : d, q, junk[0]);
        qdw_mstr_inst.cond(1'b1);
        check({30'h0, ack}, {30'h0, ack_exp});
    endtask : op
    initial
    begin
        idle(10);
        nrst = 1'b1;
        idle(8);
        check({w0, w1, w2, w3}, {4{NVR}});
        chip_sel = 1'b0;
        idle(8);
        for (int i = 0; i < 3; i++)
            qdw_mstr_inst.step(1'b1, 2'h0);
        qdw_mstr_inst.step(1'b0, 2'h3);
        qdw_mstr_inst.step(1'b0, 2'h3);
        check({w0, w1, w2, w3}, {8'hff, NVR, NVR, 8'hfc});
        store();
        wp_n = 1'b1;
        qdw_mstr_inst.step(1'b1, 2'h0);
        store();
        chip_sel = 1'b1;
        idle(8);
        op(strap, {QDW_OP_RD_NV, 4'hc}, 8'h00, 2'h3);
        check(q, NVR);
        op(strap, {QDW_OP_RD_NV, 4'h0}, 8'h00, 2'h3);
        check(q, 8'hff);
        op(strap, {QDW_OP_WR_WIPER, 4'h4}, 8'h01, 2'h3);
        check(w1, 8'h01);
        op(strap, {QDW_OP_RD_WIPER, 4'h4}, 8'h00, 2'h3);
        check(q, 8'h01);
        op(strap, {QDW_OP_WR_NV, 4'h9}, 8'h3c, 2'h3);
        op(strap, {QDW_OP_RD_NV, 4'h9}, 8'h00, 2'h3);
        check({q, w2}, {8'h3c, NVR});
        wp_n = 1'b0;
        op(strap, {QDW_OP_WR_NV, 4'ha}, 8'h55, 2'h3);
        op(strap, {QDW_OP_WIPER_TO_NV, 4'h3}, 8'h00, 2'h3);
        op(strap, {QDW_OP_RD_NV, 4'ha}, 8'h00, 2'h3);
        check(q, NVR);
        op(strap, {QDW_OP_RD_NV, 4'h3}, 8'h00, 2'h3);
        check(q, NVR);
        wp_n = 1'b1;
        op(strap, {QDW_OP_NV_TO_WIPER, 4'h9}, 8'h00, 2'h3);
        qdw_mstr_inst.step(1'b1, 2'h2);
        idle(8);
        check(w2, 8'h3c);
        op(strap, {QDW_OP_WIPER_TO_NV, 4'h6}, 8'h00, 2'h3);
        op(strap, {QDW_OP_RD_NV, 4'h6}, 8'h00, 2'h3);
        check(q, 8'h01);
        // An unknown operation code is refused after the address has been taken.
        op(strap, 8'h00, 8'h00, 2'h2);
        op(3'h2, {QDW_OP_WR_WIPER, 4'h0}, 8'h00, 2'h0);
        check(w0, 8'hff);
        for (int s = 0; s < 8; s++)
        begin
            strap = s[2:0];
            idle(8);
            op(strap, {QDW_OP_WR_WIPER, 4'hc}, {5'h00, strap}, 2'h3);
            check(w3, {29'h0, strap});
        end
        chip_sel = 1'b0;
        idle(8);
        qdw_mstr_inst.step(1'b0, 2'h1);
        qdw_mstr_inst.step(1'b0, 2'h1);
        check({w0, w1}, {8'hff, 8'h00});
        // A step made while the clock enable is low must leave no trace.
        clk_en = 1'b0;
        qdw_mstr_inst.step(1'b1, 2'h1);
        clk_en = 1'b1;
        idle(8);
        check(w1, 8'h00);
        stop_test();
    end
    initial
    begin
        repeat (60000) @(posedge clock);
        error_cnt++;
        stop_test();
    end
endmodule : qdw_wiper_ctrl_test
`default_nettype wire
